/* File: design/cpcr_config_regs.sv */
// Configuration registers for emulation, switch and attach detection,
// and the control they steer.
// Assumes a byte register port from the serial bus slave engine and
// status strobes from the emulation engine on the same clock.
`timescale 1ns/1ps
module cpcr_config_regs
#(
   parameter int unsigned CYC_PER_MS = cpcr_pkg::CYCLES_PER_MS
)
(
   input  wire logic                       clk,
   input  wire logic                       reset_n,
   input  wire logic [7:0]                 reg_addr,
   input  wire logic                       reg_wr_en,
   input  wire logic [7:0]                 reg_wr_data,
   input  wire logic                       reg_rd_en,
   output logic [7:0]                      reg_rd_data,
   input  wire logic                       mode_one_pin,
   input  wire logic                       mode_two_pin,
   input  wire logic                       emu_enable_pin,
   input  wire logic                       power_enable_pin,
   input  wire logic                       power_pol_high_pin,
   input  wire logic                       smbus_mode,
   input  wire logic                       active_state,
   input  wire cpcr_pkg::cpcr_profile_type profile,
   input  wire logic                       charging_started,
   input  wire logic                       removal_event,
   input  wire logic                       treg_exceeded,
   input  wire logic                       emu_restart,
   input  wire logic                       emu_timeout_expired,
   input  wire logic                       hs_after_accept_enable,
   input  wire logic                       profile_accepted,
   input  wire logic                       error_detected,
   input  wire logic                       error_clear,
   input  wire logic                       emu_reset_start,
   output logic                            emu_reset_active,
   output logic                            emu_reset_done,
   output logic                            hold_response,
   output logic                            hold_short,
   output logic                            hold_pin_volts,
   output logic                            remove_short,
   output logic                            hs_switch_close,
   output logic                            mode_one_eff,
   output logic                            mode_two_eff,
   output logic                            emu_enable_eff,
   output logic                            power_switch_allow,
   output logic                            detection_enable,
   output logic                            error_latched,
   output logic                            retry_request,
   output logic                            emu_timeout_disable,
   output logic                            smbus_timeout_disable,
   output logic                            emu_retry_enable,
   output logic [9:0]                      attach_th_ua,
   output logic [9:0]                      removal_th_ua
);
   import cpcr_pkg::*;

   cpcr_timer_if tif ();

   logic [7:0]       emu_cfg_ff;
   logic [7:0]       sw_cfg_ff;
   logic [7:0]       att_cfg_ff;
   logic [7:0]       rd_data_ff;
   logic [4:0]       pin_meta_ff;
   logic [4:0]       pin_sync_ff;
   cpcr_hold_type    hold_ff;
   cpcr_hold_type    nxt_hold;
   logic             short_ff;
   logic             volts_ff;
   logic             rem_short_ff;
   logic             hs_ff;
   logic             m1_ff;
   logic             m2_ff;
   logic             emu_en_ff;
   logic             pwr_ff;
   logic             det_ff;
   logic             err_ff;
   logic             retry_ff;
   logic             start_ff;
   logic [31:0]      load_ff;
   logic [9:0]       att_ua_ff;
   logic [9:0]       rem_ua_ff;
   logic             held_prof;
   logic             short_prof;
   logic             hold_exit;
   logic             pwr_pin_asrt;
   logic             pwr_bit_asrt;
   logic [9:0]       rst_ms;
   logic [9:0]       dschg_ms;
   logic [9:0]       rem_det_ua;

   // Register writes; no sleep reset exists, so contents survive Sleep
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         emu_cfg_ff <= EMU_CFG_RST;
         sw_cfg_ff  <= SW_CFG_RST;
         att_cfg_ff <= ATT_CFG_RST;
      end
      else if (reg_wr_en)
      begin
         case (reg_addr)
            EMU_CFG_ADDR: emu_cfg_ff <= reg_wr_data & EMU_CFG_MASK;
            SW_CFG_ADDR:  sw_cfg_ff  <= reg_wr_data & SW_CFG_MASK;
            ATT_CFG_ADDR: att_cfg_ff <= reg_wr_data & ATT_CFG_MASK;
            default:      ;
         endcase
      end
   end

   // Read data registered; unmapped offsets return zero
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         rd_data_ff <= 8'h00;
      else if (reg_rd_en)
      begin
         case (reg_addr)
            EMU_CFG_ADDR: rd_data_ff <= emu_cfg_ff & EMU_CFG_MASK;
            SW_CFG_ADDR:  rd_data_ff <= sw_cfg_ff & SW_CFG_MASK;
            ATT_CFG_ADDR: rd_data_ff <= att_cfg_ff;
            default:      rd_data_ff <= 8'h00;
         endcase
      end
   end

   // Two-stage synchroniser for the control pins
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pin_meta_ff <= 5'h00;
         pin_sync_ff <= 5'h00;
      end
      else
      begin
         pin_meta_ff <= {power_pol_high_pin, power_enable_pin,
                         emu_enable_pin, mode_two_pin, mode_one_pin};
         pin_sync_ff <= pin_meta_ff;
      end
   end

   // Pin and bit combination for mode, emulation and power enables
   assign pwr_pin_asrt = pin_sync_ff[3] ~^ pin_sync_ff[4];
   assign pwr_bit_asrt = sw_cfg_ff[POWER_ENABLE_PIN_BIT] ~^ pin_sync_ff[4];

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         m1_ff     <= 1'b0;
         m2_ff     <= 1'b0;
         emu_en_ff <= 1'b0;
         pwr_ff    <= 1'b0;
      end
      else if (sw_cfg_ff[OVR_BIT])
      begin
         m1_ff     <= sw_cfg_ff[MODE1_BIT];
         m2_ff     <= sw_cfg_ff[MODE2_BIT];
         emu_en_ff <= sw_cfg_ff[EMU_EN_BIT];
         pwr_ff    <= pwr_bit_asrt;
      end
      else
      begin
         m1_ff     <= sw_cfg_ff[MODE1_BIT] | pin_sync_ff[0];
         m2_ff     <= sw_cfg_ff[MODE2_BIT] | pin_sync_ff[1];
         emu_en_ff <= sw_cfg_ff[EMU_EN_BIT] | pin_sync_ff[2];
         pwr_ff    <= pwr_bit_asrt | pwr_pin_asrt;
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         det_ff <= 1'b0;
      else
         det_ff <= smbus_mode & sw_cfg_ff[DET_EN_BIT];
   end

   // Error handling: latch or auto-retry; a new error beats the clear
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         err_ff   <= 1'b0;
         retry_ff <= 1'b0;
      end
      else
      begin
         if (error_detected && smbus_mode && sw_cfg_ff[LATCH_BIT])
            err_ff <= 1'b1;
         else if (error_clear)
            err_ff <= 1'b0;
         retry_ff <= error_detected && smbus_mode
                     && !sw_cfg_ff[LATCH_BIT];
      end
   end

   // Response hold after a charging device accepts a profile
   assign held_prof  = (profile != PROF_OTHER);
   assign short_prof = (profile == PROF_DCP) || (profile == PROF_LEG3);
   assign hold_exit  = removal_event || treg_exceeded || emu_restart;

   always_comb
   begin
      nxt_hold = hold_ff;
      case (hold_ff)
         HOLD_IDLE:
            if (emu_cfg_ff[EMU_RESP_BIT] && charging_started && held_prof
                && !hold_exit)
               nxt_hold = HOLD_ON;
         HOLD_ON:
            if (hold_exit)
               nxt_hold = HOLD_IDLE;
         default:
            nxt_hold = HOLD_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         hold_ff <= HOLD_IDLE;
      else
         hold_ff <= nxt_hold;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         short_ff     <= 1'b0;
         volts_ff     <= 1'b0;
         rem_short_ff <= 1'b0;
      end
      else
      begin
         if (hold_ff == HOLD_IDLE && nxt_hold == HOLD_ON)
         begin
            short_ff <= short_prof;
            volts_ff <= (profile != PROF_CUSTOM) && !short_prof;
         end
         else if (nxt_hold == HOLD_IDLE)
         begin
            short_ff <= 1'b0;
            volts_ff <= 1'b0;
         end
         rem_short_ff <= emu_timeout_expired
                         && (nxt_hold == HOLD_IDLE);
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         hs_ff <= 1'b0;
      else
         hs_ff <= hs_after_accept_enable && profile_accepted && active_state;
   end

   // Emulation reset length is the selected interval plus discharge
   always_comb
   begin
      case (emu_cfg_ff[1:0])
         2'b00:   rst_ms = EMU_RST_MS0;
         2'b01:   rst_ms = EMU_RST_MS1;
         2'b10:   rst_ms = EMU_RST_MS2;
         default: rst_ms = EMU_RST_MS3;
      endcase
      case (att_cfg_ff[DSCHG_LSB+:2])
         2'b00:   dschg_ms = DSCHG_MS0;
         2'b01:   dschg_ms = DSCHG_MS1;
         2'b10:   dschg_ms = DSCHG_MS2;
         default: dschg_ms = DSCHG_MS3;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         start_ff <= 1'b0;
         load_ff  <= 32'h0;
      end
      else
      begin
         start_ff <= emu_reset_start;
         if (emu_reset_start)
            load_ff <= 32'(({22'h0, rst_ms} + {22'h0, dschg_ms})
                           * CYC_PER_MS);
      end
   end

   assign tif.start       = start_ff;
   assign tif.load_cycles = load_ff;

   cpcr_interval_timer u_reset_timer
   (
      .clk     (clk),
      .reset_n (reset_n),
      .tif     (tif)
   );

   // Attach and removal thresholds; Active uses a raised removal level
   always_comb
   begin
      case (att_cfg_ff[ATTACH_THRESHOLD_SEL_LSB+:2])
         2'b00:   rem_det_ua = REM_UA0;
         2'b01:   rem_det_ua = REM_UA1;
         2'b10:   rem_det_ua = REM_UA2;
         default: rem_det_ua = REM_UA3;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         att_ua_ff <= ATT_UA2;
         rem_ua_ff <= REM_UA2;
      end
      else
      begin
         case (att_cfg_ff[ATTACH_THRESHOLD_SEL_LSB+:2])
            2'b00:   att_ua_ff <= ATT_UA0;
            2'b01:   att_ua_ff <= ATT_UA1;
            2'b10:   att_ua_ff <= ATT_UA2;
            default: att_ua_ff <= ATT_UA3;
         endcase
         rem_ua_ff <= active_state ? rem_det_ua + REM_ACT_ADD_UA
                                   : rem_det_ua;
      end
   end

   assign reg_rd_data           = rd_data_ff;
   assign emu_reset_active      = tif.busy;
   assign emu_reset_done        = tif.done;
   assign hold_response         = (hold_ff == HOLD_ON);
   assign hold_short            = short_ff;
   assign hold_pin_volts        = volts_ff;
   assign remove_short          = rem_short_ff;
   assign hs_switch_close       = hs_ff;
   assign mode_one_eff          = m1_ff;
   assign mode_two_eff          = m2_ff;
   assign emu_enable_eff        = emu_en_ff;
   assign power_switch_allow    = pwr_ff;
   assign detection_enable      = det_ff;
   assign error_latched         = err_ff;
   assign retry_request         = retry_ff;
   assign emu_timeout_disable   = emu_cfg_ff[EMU_TO_DIS_BIT];
   assign smbus_timeout_disable = emu_cfg_ff[SMB_TO_DIS_BIT];
   assign emu_retry_enable      = emu_cfg_ff[EMU_RETRY_BIT];
   assign attach_th_ua          = att_ua_ff;
   assign removal_th_ua         = rem_ua_ff;

   sequence hold_cause_s;
      hold_ff == HOLD_IDLE && emu_cfg_ff[EMU_RESP_BIT] && charging_started
      && held_prof && !hold_exit;
   endsequence

   hold_enter_a: assert property (@(posedge clk)
      disable iff (!reset_n)
      hold_cause_s |=> hold_ff == HOLD_ON)
      else $error("response hold not entered");
   hold_exit_a: assert property (@(posedge clk)
      disable iff (!reset_n)
      hold_ff == HOLD_ON && hold_exit |=> hold_ff == HOLD_IDLE && !short_ff)
      else $error("response hold not released");
   short_kind_a: assert property (@(posedge clk)
      disable iff (!reset_n)
      hold_cause_s ##0 (short_prof) |=> short_ff && !volts_ff)
      else $error("short not held for short profile");
   short_removal_a: assert property (@(posedge clk)
      disable iff (!reset_n)
      !emu_cfg_ff[EMU_RESP_BIT] && emu_timeout_expired |=> rem_short_ff)
      else $error("short not removed at timeout");
   reset_length_a: assert property (@(posedge clk)
      disable iff (!reset_n)
      emu_reset_start |=> load_ff == 32'(({22'h0, $past(rst_ms)}
         + {22'h0, $past(dschg_ms)}) * CYC_PER_MS) ##1 tif.busy)
      else $error("emulation reset length wrong");
   pin_override_a: assert property (@(posedge clk)
      disable iff (!reset_n)
      sw_cfg_ff[OVR_BIT] |=> m1_ff == $past(sw_cfg_ff[MODE1_BIT])
         && emu_en_ff == $past(sw_cfg_ff[EMU_EN_BIT]))
      else $error("pin override not honoured");
   pin_or_a: assert property (@(posedge clk)
      disable iff (!reset_n)
      !sw_cfg_ff[OVR_BIT] |=> m2_ff == $past(sw_cfg_ff[MODE2_BIT]
         | pin_sync_ff[1]))
      else $error("mode two not ORed with pin");
   power_allow_a: assert property (@(posedge clk)
      disable iff (!reset_n)
      !sw_cfg_ff[OVR_BIT] && pin_sync_ff[4]
      && (pin_sync_ff[3] || sw_cfg_ff[POWER_ENABLE_PIN_BIT]) |=> pwr_ff)
      else $error("power switch not allowed");
   error_latch_a: assert property (@(posedge clk)
      disable iff (!reset_n)
      error_detected && smbus_mode && sw_cfg_ff[LATCH_BIT]
      |=> err_ff && !retry_ff)
      else $error("error not latched");
   auto_retry_a: assert property (@(posedge clk)
      disable iff (!reset_n)
      error_detected && smbus_mode && !sw_cfg_ff[LATCH_BIT]
      |=> retry_ff ##1 !retry_ff || $past(error_detected))
      else $error("auto retry not requested");
   unimpl_read_a: assert property (@(posedge clk)
      disable iff (!reset_n)
      reg_rd_en && reg_addr == EMU_CFG_ADDR |=> rd_data_ff[6:5] == 2'b00)
      else $error("unimplemented bits read nonzero");
endmodule : cpcr_config_regs

/* File: inc/cpcr_pkg.sv */
// Constants and types for the charger port configuration registers.
// Assumes a 200 MHz system clock and a byte-wide register port from the
// serial bus slave engine.
// What this block does
// - Hold set and device charging: keep last line response until an exit.
// - While holding, DCP and Legacy 3 keep short; others except Custom keep pin voltages.
// - Response-hold clear: remove the short when emulation timeout expires.
// - Reset interval select: 00=50, 01=75, 10=125, 11=175 ms.
// - Emulation reset time is the selected interval plus discharge time.
// - High-speed-after-accept enable closes the switch in Active state regardless of hold.
// - Pin override set: mode, power and emulation enables come from bits only.
// - Pin override clear: each control is pin OR register bit.
// - Bits 5, 4, 3 are emulation enable, mode two, mode one.
// - In serial bus mode, detection enable bit turns detection on.
// - Switch allowed when power bit or pin asserted; polarity decoded.
// - Latch mode in serial bus mode holds errors until the host clears them.
// - Auto-retry mode in serial bus mode retries after each error.
// - Discharge select: 00=100, 01=200, 10=300, 11=400 ms.
// - Threshold select: 200/100, 400/300, 800/700, 1000/900 uA.
// - Removal threshold differs between Active and Detect power states.
// - Register contents are retained in Sleep.
package cpcr_pkg;
   localparam logic [7:0]  EMU_CFG_ADDR   = 8'h16;
   localparam logic [7:0]  SW_CFG_ADDR    = 8'h17;
   localparam logic [7:0]  ATT_CFG_ADDR   = 8'h18;
   localparam logic [7:0]  EMU_CFG_RST    = 8'h8C;
   localparam logic [7:0]  SW_CFG_RST     = 8'h04;
   localparam logic [7:0]  ATT_CFG_RST    = 8'h46;
   localparam logic [7:0]  EMU_CFG_MASK   = 8'h9F;
   localparam logic [7:0]  SW_CFG_MASK    = 8'hBF;
   localparam logic [7:0]  ATT_CFG_MASK   = 8'hFF;
   // Field positions
   localparam int          EMU_RESP_BIT   = 2;
   localparam int          EMU_TO_DIS_BIT = 4;
   localparam int          EMU_RETRY_BIT  = 3;
   localparam int          SMB_TO_DIS_BIT = 7;
   localparam int          OVR_BIT        = 7;
   localparam int          EMU_EN_BIT     = 5;
   localparam int          MODE2_BIT      = 4;
   localparam int          MODE1_BIT      = 3;
   localparam int          DET_EN_BIT     = 2;
   localparam int          POWER_ENABLE_PIN_BIT     = 1;
   localparam int          LATCH_BIT      = 0;
   localparam int          DSCHG_LSB      = 2;
   localparam int          ATTACH_THRESHOLD_SEL_LSB     = 0;
   // Timing
   localparam int unsigned CLK_PERIOD_PS  = 5000;
   localparam int unsigned MS_IN_PS       = 1000000000;
   localparam int unsigned CYCLES_PER_MS  = MS_IN_PS / CLK_PERIOD_PS;
   localparam logic [9:0]  EMU_RST_MS0    = 10'd50;
   localparam logic [9:0]  EMU_RST_MS1    = 10'd75;
   localparam logic [9:0]  EMU_RST_MS2    = 10'd125;
   localparam logic [9:0]  EMU_RST_MS3    = 10'd175;
   localparam logic [9:0]  DSCHG_MS0      = 10'd100;
   localparam logic [9:0]  DSCHG_MS1      = 10'd200;
   localparam logic [9:0]  DSCHG_MS2      = 10'd300;
   localparam logic [9:0]  DSCHG_MS3      = 10'd400;
   // Thresholds in uA
   localparam logic [9:0]  ATT_UA0        = 10'd200;
   localparam logic [9:0]  ATT_UA1        = 10'd400;
   localparam logic [9:0]  ATT_UA2        = 10'd800;
   localparam logic [9:0]  ATT_UA3        = 10'd1000;
   localparam logic [9:0]  REM_UA0        = 10'd100;
   localparam logic [9:0]  REM_UA1        = 10'd300;
   localparam logic [9:0]  REM_UA2        = 10'd700;
   localparam logic [9:0]  REM_UA3        = 10'd900;
   localparam logic [9:0]  REM_ACT_ADD_UA = 10'd50;

   typedef enum logic [3:0] {
      PROF_DCP, PROF_CUSTOM, PROF_LEG1, PROF_LEG2, PROF_LEG3,
      PROF_LEG4, PROF_LEG5, PROF_LEG6, PROF_LEG7, PROF_OTHER
   } cpcr_profile_type;

   typedef enum logic {HOLD_IDLE, HOLD_ON} cpcr_hold_type;
endpackage : cpcr_pkg

/* File: inc/cpcr_timer_if.sv */
// Interface between the register block and its interval timer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface cpcr_timer_if;
   logic        start;
   logic [31:0] load_cycles;
   logic        busy;
   logic        done;
   modport ctrl (output start, output load_cycles, input busy, input done);
   modport tmr  (input start, input load_cycles, output busy, output done);
endinterface : cpcr_timer_if

/* File: design/cpcr_interval_timer.sv */
// Down-counter that measures one interval of a loaded length in cycles.
// Assumes start is a one-cycle pulse on the same clock.
`timescale 1ns/1ps
module cpcr_interval_timer
(
   input wire logic clk,
   input wire logic reset_n,
   cpcr_timer_if.tmr tif
);
   import cpcr_pkg::*;

   logic [31:0] count_ff;
   logic        done_ff;
   logic        busy_ff;

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         count_ff <= 32'h0;
      else if (tif.start)
         count_ff <= tif.load_cycles;
      else if (count_ff != 32'h0)
         count_ff <= count_ff - 32'h1;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         done_ff <= 1'b0;
      else
         done_ff <= !tif.start && (count_ff == 32'h1);
   end

   // Busy is registered; it equals count != 0 in the same cycle
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         busy_ff <= 1'b0;
      else if (tif.start)
         busy_ff <= (tif.load_cycles != 32'h0);
      else
         busy_ff <= (count_ff > 32'h1);
   end

   assign tif.busy = busy_ff;
   assign tif.done = done_ff;

   timer_done_a: assert property (@(posedge clk)
      disable iff (!reset_n)
      (count_ff == 32'h1 && !tif.start) |=> done_ff && count_ff == 32'h0)
      else $error("interval timer missed its end");
endmodule : cpcr_interval_timer

/* File: tb/cpcr_pd_model.sv */
// Portable device stand-in: draws charge on attach, reports unplug.
// Assumes the bench raises attach to plug in and lowers it to unplug.
`timescale 1ns/1ps
module cpcr_pd_model
(
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic attach,
   output logic      charging_started,
   output logic      removal_event
);
   logic att_ff;
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         att_ff           <= 1'b0;
         charging_started <= 1'b0;
         removal_event    <= 1'b0;
      end
      else
      begin
         att_ff           <= attach;
         charging_started <= attach & ~att_ff;
         removal_event    <= ~attach & att_ff;
      end
   end
endmodule : cpcr_pd_model

/* File: tb/tb_top.sv */
// Self-checking bench for the configuration register block.
// Assumes the package and the device stand-in are compiled first.
`timescale 1ns/1ps
module tb_top;
   import cpcr_pkg::*;
   typedef struct packed
   {
      logic [7:0] sw;
      logic [3:0] pin;
      logic [4:0] eff;
   } cpcr_row_type;
   localparam int CYC = 10;
   logic clk = 1'b0, reset_n = 1'b0, reg_wr_en = 1'b0, reg_rd_en = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wr_data = 8'h00, reg_rd_data;
   logic mode_one_pin = 1'b0, mode_two_pin = 1'b0, emu_enable_pin = 1'b0;
   logic power_enable_pin = 1'b0, power_pol_high_pin = 1'b1;
   logic smbus_mode = 1'b1, active_state = 1'b0, treg_exceeded = 1'b0;
   logic emu_restart = 1'b0, emu_timeout_expired = 1'b0, attach = 1'b0;
   logic hs_after_accept_enable = 1'b0, profile_accepted = 1'b0;
   logic error_detected = 1'b0, error_clear = 1'b0, emu_reset_start = 1'b0;
   cpcr_profile_type profile = PROF_DCP;
   logic charging_started, removal_event, emu_reset_active, emu_reset_done;
   logic hold_response, hold_short, hold_pin_volts, remove_short;
   logic hs_switch_close, mode_one_eff, mode_two_eff, emu_enable_eff;
   logic power_switch_allow, detection_enable, error_latched;
   logic retry_request, emu_timeout_disable, smbus_timeout_disable;
   logic emu_retry_enable, seen;
   logic [9:0] attach_th_ua, removal_th_ua;
   logic [9:0] att_e [4] = '{10'd200, 10'd400, 10'd800, 10'd1000};
   logic [9:0] rem_e [4] = '{10'd100, 10'd300, 10'd700, 10'd900};
   int rst_ms [4] = '{50, 75, 125, 175};
   int dis_ms [4] = '{100, 200, 300, 400};
   int bad_count = 0, total_checks = 0, i, n;
   cpcr_row_type rows [5] = '{'{8'h04, 4'hF, 5'h1F}, '{8'h80, 4'hF, 5'h00},
      '{8'hBE, 4'h0, 5'h1F}, '{8'h08, 4'h0, 5'h10}, '{8'h02, 4'h0, 5'h02}};
   cpcr_config_regs #(.CYC_PER_MS(CYC)) dut (.*);
   cpcr_pd_model pd (.*);
   always #2.5 clk = ~clk;
   task automatic tick(input int k = 1);
      repeat (k) @(posedge clk);
      #1;
   endtask : tick
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wr_data = d;
      reg_wr_en = 1'b1;
      tick();
      reg_wr_en = 1'b0;
      tick();
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      reg_addr = a;
      reg_rd_en = 1'b1;
      tick();
      reg_rd_en = 1'b0;
      chk(reg_rd_data, e);
      tick();
   endtask : rd
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : wrap_up
   initial
   begin
      tick(6);
      reset_n = 1'b1;
      tick();
      rd(8'h16, 8'h8C);
      rd(8'h17, 8'h04);
      rd(8'h18, 8'h46);
      rd(8'h20, 8'h00);
      wr(8'h16, 8'hFF);
      rd(8'h16, 8'h9F);
      chk({emu_timeout_disable, smbus_timeout_disable, emu_retry_enable},
          3'b111);
      wr(8'h17, 8'hFF);
      rd(8'h17, 8'hBF);
      foreach (rows[k])
      begin
         wr(8'h17, rows[k].sw);
         {mode_one_pin, mode_two_pin, emu_enable_pin, power_enable_pin} =
            rows[k].pin;
         tick(4);
         chk({mode_one_eff, mode_two_eff, emu_enable_eff, power_switch_allow,
              detection_enable}, rows[k].eff);
      end
      {power_pol_high_pin, power_enable_pin} = 2'b01;
      tick(4);
      chk(power_switch_allow, 1'b0);
      power_enable_pin = 1'b0;
      tick(4);
      chk(power_switch_allow, 1'b1);
      {power_pol_high_pin, power_enable_pin} = 2'b10;
      for (int k = 0; k < 4; k++)
      begin
         wr(8'h16, 8'h8C | k[7:0]);
         wr(8'h18, 8'h40 | k[7:0] | (k[7:0] << 2));
         active_state = 1'b0;
         tick(2);
         chk(attach_th_ua, att_e[k]);
         chk(removal_th_ua, rem_e[k]);
         active_state = 1'b1;
         tick(2);
         chk(removal_th_ua, rem_e[k] + REM_ACT_ADD_UA);
         emu_reset_start = 1'b1;
         tick();
         emu_reset_start = 1'b0;
         n = 0;
         for (i = 0; i < 7000 && emu_reset_done !== 1'b1; i++)
         begin
            tick();
            n += (emu_reset_active === 1'b1);
         end
         chk(n[15:0], 16'((rst_ms[k] + dis_ms[k]) * CYC));
         if (emu_reset_done !== 1'b1)
         begin
            bad_count++;
            $display("BAD %0t reset timer hung", $time);
            wrap_up();
         end
      end
      attach = 1'b1;
      tick(3);
      chk({hold_response, hold_short, hold_pin_volts}, 3'b110);
      emu_timeout_expired = 1'b1;
      tick();
      emu_timeout_expired = 1'b0;
      seen = remove_short;
      tick();
      chk(seen | remove_short, 1'b0);
      attach = 1'b0;
      tick(3);
      chk(hold_response, 1'b0);
      profile = PROF_LEG5;
      attach = 1'b1;
      tick(3);
      chk({hold_response, hold_short, hold_pin_volts}, 3'b101);
      treg_exceeded = 1'b1;
      tick();
      treg_exceeded = 1'b0;
      tick();
      chk(hold_response, 1'b0);
      wr(8'h16, 8'h8B);
      emu_timeout_expired = 1'b1;
      tick();
      emu_timeout_expired = 1'b0;
      seen = remove_short;
      tick();
      chk(seen | remove_short, 1'b1);
      chk(hs_switch_close, 1'b0);
      hs_after_accept_enable = 1'b1;
      profile_accepted = 1'b1;
      tick(2);
      chk(hs_switch_close, 1'b1);
      wr(8'h17, 8'h01);
      error_detected = 1'b1;
      tick();
      error_detected = 1'b0;
      tick(3);
      chk(error_latched, 1'b1);
      error_clear = 1'b1;
      tick();
      error_clear = 1'b0;
      tick();
      chk(error_latched, 1'b0);
      wr(8'h17, 8'h00);
      error_detected = 1'b1;
      tick();
      error_detected = 1'b0;
      seen = retry_request;
      tick();
      chk({seen | retry_request, error_latched}, 2'b10);
      smbus_mode = 1'b0;
      wr(8'h17, 8'h05);
      error_detected = 1'b1;
      tick();
      error_detected = 1'b0;
      seen = retry_request;
      tick();
      chk({seen | retry_request, error_latched, detection_enable},
          3'b000);
      smbus_mode = 1'b1;
      reset_n = 1'b0;
      tick();
      chk(attach_th_ua, 10'd800);
      reset_n = 1'b1;
      tick();
      rd(8'h17, 8'h04);
      rd(8'h16, 8'h8C);
      wrap_up();
   end
endmodule : tb_top
